//--- rtl/queue_coalesce_top.sv
// Purpose : Queue-count negotiation and per-vector interrupt coalescing.
// Assumes : Software drives the plain register port; events come from same-clock logic.
// Notes   : Vector 0 serves the admin completion queue and is never held back.
//
// Overview of operation
// - Allocated counts stay fixed until next reset.
// - Set and get return allocation in result word.
// - Bits 31:16 request completion queues, zero-based.
// - Bits 15:0 request submission queues, zero-based.
// - All-ones request field gives invalid field error.
// - Allocation reported zero-based, at least one each.
// - Allocation may shrink or round up to unit.
// - Interrupt when time or threshold is met.
// - Zero time or threshold disables aggregation.
// - Admin vector interrupts are never coalesced.
// - Error completions interrupt without aggregation delay.
// - Head doorbell restarts vector counter and timer.
// - Coalescing get returns current time and threshold.
// - Interrupt mode change drops coalescing settings.
// - Time field 15:8 in 100 us units.
// - Threshold field 7:0, zero-based, resets zero.
// - Per-vector disable bit bypasses coalescing.
`timescale 1ns/1ps
module queue_coalesce_top #(
   parameter int NUM_VECTORS = 8,                                 // Interrupt vectors.
   parameter int VEC_W       = 3,                                 // Width of a vector index.
   parameter int MAX_CQ      = 64,                                // Completion queues owned.
   parameter int MAX_SQ      = 64,                                // Submission queues owned.
   parameter int ALLOC_UNIT  = 4,                                 // Queue allocation unit.
   parameter int TICK_CYCLES = qa_coalesce_pkg::TICK_CYCLES_DEF   // Cycles per time unit.
) (
   input  wire logic                   ref_clk,      // Controller clock, 50 MHz.
   input  wire logic                   arst_n,       // Asynchronous active-low reset.
   input  wire logic [7:0]             regAddr,      // Register byte address.
   input  wire logic [31:0]            regWrData,    // Register write data.
   input  wire logic                   regWrStb,     // Register write strobe.
   input  wire logic                   regRdStb,     // Register read strobe.
   output logic      [31:0]            regRdData,    // Read data, cycle after strobe.
   input  wire logic                   entryValid,   // Completion entry posted.
   input  wire logic [VEC_W-1:0]       entryVector,  // Vector of that entry.
   input  wire logic                   entryError,   // That entry reports an error.
   input  wire logic                   doorbellWr,   // Completion head doorbell written.
   input  wire logic [VEC_W-1:0]       doorbellVec,  // Vector of that doorbell.
   input  wire logic                   intModeChg,   // Interrupt mode changed, pulse.
   output logic      [NUM_VECTORS-1:0] irqFire,      // Per-vector interrupt pulse.
   output logic                        cplValid,     // Feature command completed, pulse.
   output logic      [31:0]            cplDword0,    // Completion dword 0.
   output logic                        cplInvalid,   // Invalid field in command.
   output logic      [15:0]            cq_count_allocated, // Allocated completion queues.
   output logic      [15:0]            sq_count_allocated  // Allocated submission queues.
);

   // ==========================================================================
   // Reset release: asynchronous assertion, two-flop synchronised release.
   logic rstSync1_q;
   logic rst_n;

   // The release is retimed so no flop sees reset lift near its clock edge.
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         rstSync1_q <= 1'b0;
         rst_n      <= 1'b0;
      end else begin
         rstSync1_q <= 1'b1;
         rst_n      <= rstSync1_q;
      end
   end

   // ==========================================================================
   // Register port decode.
   logic        wrArg;
   logic        wrIssue;
   logic        wrVecOff;
   logic [31:0] cmdArg_q;        // Argument word of the next command.
   logic [31:0] result_q;        // Dword 0 of the last completion.
   logic        done_q;          // A command has completed since reset.
   logic        invalid_q;       // The last command failed with invalid field.
   logic [NUM_VECTORS-1:0] vector_coalesce_off;

   always_comb begin
      wrArg    = regWrStb && (regAddr == qa_coalesce_pkg::OFS_CMD_ARG);
      wrIssue  = regWrStb && (regAddr == qa_coalesce_pkg::OFS_CMD_ISSUE);
      wrVecOff = regWrStb && (regAddr == qa_coalesce_pkg::OFS_VEC_OFF);
   end

   // Argument register; a write here does not start anything on its own.
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         cmdArg_q <= qa_coalesce_pkg::ARG_RESET;
      end else if (wrArg) begin
         cmdArg_q <= regWrData;
      end
   end

   // ==========================================================================
   // Command decode: an issue write names the feature and set or get.
   logic [7:0]  issueFid;
   logic        issueSet;
   logic [15:0] cqReq;
   logic [15:0] sqReq;
   logic [15:0] cqGrant;
   logic [15:0] sqGrant;
   logic        reqBad;

   always_comb begin
      issueFid = regWrData[7:0];
      issueSet = regWrData[qa_coalesce_pkg::ISSUE_SET_BIT];
      cqReq    = cmdArg_q[qa_coalesce_pkg::CQ_FIELD_LSB +: 16];
      sqReq    = cmdArg_q[qa_coalesce_pkg::SQ_FIELD_LSB +: 16];
   end

   queue_alloc #(
      .MAX_CQ     (MAX_CQ),
      .MAX_SQ     (MAX_SQ),
      .ALLOC_UNIT (ALLOC_UNIT)
   ) u_alloc (
      .cqReq   (cqReq),
      .sqReq   (sqReq),
      .cqAlloc (cqGrant),
      .sqAlloc (sqGrant),
      .reqBad  (reqBad)
   );

   // ==========================================================================
   // Queue allocation: fixed by the first good set, held until reset.
   // The host is expected to negotiate before creating any queue; this block
   // cannot see queue creation, so it simply refuses to change once locked.
   logic        allocLocked_q;
   logic [15:0] cqAlloc_q;
   logic [15:0] sqAlloc_q;
   logic        qcSet;

   assign qcSet = wrIssue && issueSet && (issueFid == qa_coalesce_pkg::FID_QUEUE_COUNT);

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         allocLocked_q <= 1'b0;
         cqAlloc_q     <= 16'(MAX_CQ - 1);
         sqAlloc_q     <= 16'(MAX_SQ - 1);
      end else if (qcSet && !reqBad && !allocLocked_q) begin
         allocLocked_q <= 1'b1;
         cqAlloc_q     <= cqGrant;
         sqAlloc_q     <= sqGrant;
      end
   end

   assign cq_count_allocated = cqAlloc_q;
   assign sq_count_allocated = sqAlloc_q;

   // ==========================================================================
   // Coalescing settings: reset to zero; time and threshold also dropped on interrupt mode change.
   logic [7:0] aggTime_q;                 // Delay limit in 100 us units.
   logic [7:0] entry_aggregation_limit;   // Zero-based entry threshold.
   logic       coSet;

   assign coSet = wrIssue && issueSet && (issueFid == qa_coalesce_pkg::FID_COALESCE);

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         aggTime_q               <= qa_coalesce_pkg::AGG_TIME_RESET;
         entry_aggregation_limit <= qa_coalesce_pkg::AGG_LIMIT_RESET;
      end else if (coSet) begin
         aggTime_q               <= cmdArg_q[qa_coalesce_pkg::TIME_FIELD_LSB +: 8];
         entry_aggregation_limit <= cmdArg_q[qa_coalesce_pkg::LIMIT_FIELD_LSB +: 8];
      end else if (intModeChg) begin
         aggTime_q               <= qa_coalesce_pkg::AGG_TIME_RESET;
         entry_aggregation_limit <= qa_coalesce_pkg::AGG_LIMIT_RESET;
      end
   end

   // Per-vector disable mask; a one bypasses coalescing for that vector.
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         vector_coalesce_off <= '0;
      end else if (wrVecOff) begin
         vector_coalesce_off <= regWrData[NUM_VECTORS-1:0];
      end
   end

   // ==========================================================================
   // Completion of a feature command: result word plus status pulse.
   logic [31:0] cplWord;
   logic        cplBad;

   always_comb begin
      cplWord = 32'h00000000;
      cplBad  = 1'b0;
      if (issueFid == qa_coalesce_pkg::FID_QUEUE_COUNT) begin
         if (issueSet && reqBad) begin
            cplBad = 1'b1;
         end else if (issueSet && !allocLocked_q) begin
            cplWord = {cqGrant, sqGrant};
         end else begin
            cplWord = {cqAlloc_q, sqAlloc_q};
         end
      end else if (issueFid == qa_coalesce_pkg::FID_COALESCE) begin
         if (issueSet) begin
            cplWord = {16'h0000, cmdArg_q[15:0]};
         end else begin
            cplWord = {16'h0000, aggTime_q, entry_aggregation_limit};
         end
      end else begin
         cplBad = 1'b1;
      end
   end

   // The completion is captured so downstream logic sees stable flops.
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         cplValid   <= 1'b0;
         cplDword0  <= 32'h00000000;
         cplInvalid <= 1'b0;
      end else begin
         cplValid   <= wrIssue;
         cplDword0  <= (wrIssue && !cplBad) ? cplWord : 32'h00000000;
         cplInvalid <= wrIssue && cplBad;
      end
   end

   // Software-visible copy of the last completion.
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         result_q  <= 32'h00000000;
         done_q    <= 1'b0;
         invalid_q <= 1'b0;
      end else if (wrIssue) begin
         result_q  <= cplBad ? 32'h00000000 : cplWord;
         done_q    <= 1'b1;
         invalid_q <= cplBad;
      end
   end

   // ==========================================================================
   // Time base shared by every vector; each vector counts its own delay in these units.
   logic [15:0] tickCnt_q;
   logic        tick;

   assign tick = (tickCnt_q == 16'(TICK_CYCLES - 1));

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         tickCnt_q <= 16'h0000;
      end else if (tick) begin
         tickCnt_q <= 16'h0000;
      end else begin
         tickCnt_q <= tickCnt_q + 16'h0001;
      end
   end

   // ==========================================================================
   // One coalescer per vector; vector 0 always bypasses.
   genvar v;
   generate
      for (v = 0; v < NUM_VECTORS; v++) begin : g_vec
         coalesce_if cif ();

         assign cif.entry    = entryValid && (entryVector == VEC_W'(v));
         assign cif.entryErr = entryError;
         assign cif.doorbell = doorbellWr && (doorbellVec == VEC_W'(v));
         assign cif.bypass   = (v == 0) || vector_coalesce_off[v];
         assign cif.tick     = tick;
         assign cif.aggTime  = aggTime_q;
         assign cif.aggLimit = entry_aggregation_limit;
         assign irqFire[v]   = cif.fire;

         coalesce_vector u_vec (
            .ref_clk (ref_clk),
            .rst_n   (rst_n),
            .cif     (cif)
         );
      end
   endgenerate

   // ==========================================================================
   // Read port: data stand one cycle after the strobe, zero when unmapped.
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         regRdData <= 32'h00000000;
      end else if (regRdStb) begin
         unique case (regAddr)
            qa_coalesce_pkg::OFS_CMD_ARG:   regRdData <= cmdArg_q;
            qa_coalesce_pkg::OFS_RESULT:    regRdData <= result_q;
            qa_coalesce_pkg::OFS_STATUS: begin
               regRdData <= 32'h00000000;
               regRdData[qa_coalesce_pkg::ST_DONE_BIT]    <= done_q;
               regRdData[qa_coalesce_pkg::ST_INVALID_BIT] <= invalid_q;
               regRdData[qa_coalesce_pkg::ST_LOCKED_BIT]  <= allocLocked_q;
            end
            qa_coalesce_pkg::OFS_VEC_OFF:   regRdData <= 32'(vector_coalesce_off);
            qa_coalesce_pkg::OFS_ALLOC_CFG: regRdData <= {cqAlloc_q, sqAlloc_q};
            default:                        regRdData <= 32'h00000000;
         endcase
      end else begin
         regRdData <= 32'h00000000;
      end
   end

endmodule

//--- rtl/qa_coalesce_pkg.sv
// Purpose : Shared constants for the queue allocation and interrupt coalescing block.
// Assumes : A 50 MHz controller clock and a plain register port of 32-bit words.
// Notes   : Offsets, field positions, the argument and coalescing reset values and the tick count live here.
package qa_coalesce_pkg;

   // ==========================================================================
   // Feature identifiers.
   localparam logic [7:0]  FID_QUEUE_COUNT = 8'h07;
   localparam logic [7:0]  FID_COALESCE    = 8'h08;

   // ==========================================================================
   // Register byte offsets.
   localparam logic [7:0]  OFS_CMD_ARG     = 8'h00;
   localparam logic [7:0]  OFS_CMD_ISSUE   = 8'h04;
   localparam logic [7:0]  OFS_RESULT      = 8'h08;
   localparam logic [7:0]  OFS_STATUS      = 8'h0C;
   localparam logic [7:0]  OFS_VEC_OFF     = 8'h10;
   localparam logic [7:0]  OFS_ALLOC_CFG   = 8'h14;

   // ==========================================================================
   // Field positions inside the argument and result words.
   localparam int          CQ_FIELD_LSB    = 16;
   localparam int          SQ_FIELD_LSB    = 0;
   localparam int          TIME_FIELD_LSB  = 8;
   localparam int          LIMIT_FIELD_LSB = 0;
   localparam int          ISSUE_SET_BIT   = 8;
   localparam int          ST_DONE_BIT     = 0;
   localparam int          ST_INVALID_BIT  = 1;
   localparam int          ST_LOCKED_BIT   = 2;
   localparam logic [15:0] COUNT_ILLEGAL   = 16'hFFFF;

   // ==========================================================================
   // Values after reset.
   localparam logic [7:0]  AGG_TIME_RESET  = 8'h00;
   localparam logic [7:0]  AGG_LIMIT_RESET = 8'h00;
   localparam logic [31:0] ARG_RESET       = 32'h00000000;

   // ==========================================================================
   // Timing: one aggregation-time unit, and the clock period.
   localparam int          AGG_UNIT_US     = 100;
   localparam int          CLK_PERIOD_NS   = 20;
   localparam int          TICK_CYCLES_DEF = (AGG_UNIT_US * 1000) / CLK_PERIOD_NS;

endpackage

//--- rtl/coalesce_if.sv
// Purpose : Carries one vector's settings and events between top and coalescer.
// Assumes : All signals run on the controller clock.
// Notes   : One instance per interrupt vector.
`timescale 1ns/1ps
interface coalesce_if;
   logic       entry;      // A completion entry was posted to this vector.
   logic       entryErr;   // That entry reports an error.
   logic       doorbell;   // Head doorbell write for this vector.
   logic       bypass;     // Coalescing is off for this vector.
   logic       tick;       // One aggregation-time unit has elapsed.
   logic [7:0] aggTime;    // Delay limit in time units.
   logic [7:0] aggLimit;   // Zero-based entry threshold.
   logic       fire;       // One-cycle interrupt request.

   modport ctrl (output entry, entryErr, doorbell, bypass, tick, aggTime, aggLimit, input fire);
   modport vec  (input entry, entryErr, doorbell, bypass, tick, aggTime, aggLimit, output fire);
endinterface

//--- rtl/queue_alloc.sv
// Purpose : Turns a requested queue count pair into an allocated pair.
// Assumes : Requests and results are zero-based; ALLOC_UNIT is a power of two.
// Notes   : Purely combinational; the top decides when the result is kept.
`timescale 1ns/1ps
module queue_alloc #(
   parameter int MAX_CQ     = 64,  // Completion queues the controller owns.
   parameter int MAX_SQ     = 64,  // Submission queues the controller owns.
   parameter int ALLOC_UNIT = 4    // Queues are handed out in multiples of this.
) (
   input  wire logic [15:0] cqReq,     // Requested completion queues, zero-based.
   input  wire logic [15:0] sqReq,     // Requested submission queues, zero-based.
   output logic      [15:0] cqAlloc,   // Allocated completion queues, zero-based.
   output logic      [15:0] sqAlloc,   // Allocated submission queues, zero-based.
   output logic             reqBad     // A field holds the illegal all-ones value.
);

   // ==========================================================================
   // Round up to the allocation unit, clamp to what exists, return zero-based.
   function automatic logic [15:0] grant(input logic [15:0] req, input int avail);
      logic [16:0] want;
      logic [16:0] cap;
      want = {1'b0, req} + 17'h00001;
      want = (want + 17'(ALLOC_UNIT - 1)) & ~17'(ALLOC_UNIT - 1);
      cap  = 17'(avail);
      if (want > cap) begin
         want = cap;
      end
      if (want == 17'h00000) begin
         want = 17'h00001;
      end
      grant = 16'(want - 17'h00001);
   endfunction

   // Both fields get the same treatment with their own limit.
   always_comb begin
      cqAlloc = grant(cqReq, MAX_CQ);
      sqAlloc = grant(sqReq, MAX_SQ);
      reqBad  = (cqReq == qa_coalesce_pkg::COUNT_ILLEGAL) ||
                (sqReq == qa_coalesce_pkg::COUNT_ILLEGAL);
   end

endmodule

//--- rtl/coalesce_vector.sv
// Purpose : Per-vector entry counter and delay timer that decide when to interrupt.
// Assumes : Settings are stable while entries are pending, else the new value applies.
// Notes   : The fire output is registered, so it follows its cause by one cycle.
`timescale 1ns/1ps
module coalesce_vector (
   input  wire logic ref_clk,   // Controller clock.
   input  wire logic rst_n,     // Synchronised active-low reset.
   coalesce_if.vec   cif        // Settings in, interrupt request out.
);

   logic [8:0] pendCnt_q;    // Entries gathered since the last interrupt or doorbell.
   logic [8:0] pendCnt_d;
   logic [7:0] timer_q;      // Time units elapsed since the first pending entry.
   logic [7:0] timer_d;
   logic       active_q;     // At least one entry is pending.
   logic       active_d;
   logic       fire_q;
   logic       fireNow;
   logic       noAgg;

   // ==========================================================================
   // Next-state logic: restart on doorbell, count entries, watch both limits.
   always_comb begin
      noAgg     = cif.bypass || (cif.aggTime == 8'h00) || (cif.aggLimit == 8'h00);
      pendCnt_d = cif.doorbell ? 9'h000 : pendCnt_q;
      timer_d   = cif.doorbell ? 8'h00 : timer_q;
      active_d  = cif.doorbell ? 1'b0 : active_q;
      if (active_d && cif.tick && (timer_d != 8'hFF)) begin
         timer_d = timer_d + 8'h01;
      end
      if (cif.entry) begin
         pendCnt_d = pendCnt_d + 9'h001;
         active_d  = 1'b1;
      end
      fireNow = (cif.entry && (noAgg || cif.entryErr)) ||
                (pendCnt_d > {1'b0, cif.aggLimit}) ||
                (active_d && (timer_d >= cif.aggTime));
      if (fireNow) begin
         pendCnt_d = 9'h000;
         timer_d   = 8'h00;
         active_d  = 1'b0;
      end
   end

   // State registers of the vector.
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         pendCnt_q <= 9'h000;
         timer_q   <= 8'h00;
         active_q  <= 1'b0;
         fire_q    <= 1'b0;
      end else begin
         pendCnt_q <= pendCnt_d;
         timer_q   <= timer_d;
         active_q  <= active_d;
         fire_q    <= fireNow;
      end
   end

   assign cif.fire = fire_q;

endmodule

//--- tb/qc_checker.sv
// Purpose : Port-level assertions for the queue count and coalescing block.
// Assumes : One clock; arst_n low switches every check off.
// Notes   : Helper registers remember the last argument and feature issued.
`timescale 1ns/1ps
module qc_checker #(
   parameter int NUM_VECTORS = 8, parameter int VEC_W = 3, parameter int MAX_CQ = 64
) (
   input wire logic                   ref_clk,            // Clock.
   input wire logic                   arst_n,             // Reset.
   input wire logic [7:0]             regAddr,            // Address.
   input wire logic [31:0]            regWrData,          // Write data.
   input wire logic                   regWrStb,           // Write strobe.
   input wire logic                   entryValid,         // Entry posted.
   input wire logic [VEC_W-1:0]       entryVector,        // Entry vector.
   input wire logic                   entryError,         // Entry in error.
   input wire logic [NUM_VECTORS-1:0] irqFire,            // Interrupts.
   input wire logic                   cplValid,           // Completion.
   input wire logic [31:0]            cplDword0,          // Result.
   input wire logic                   cplInvalid,         // Refused.
   input wire logic [15:0]            cq_count_allocated, // Held count.
   input wire logic [15:0]            sq_count_allocated  // Held count.
);
   // ==========================================================================
   // Helpers: an issue write, and a queue-count set among them.
   logic [31:0] argQ;
   logic [7:0]  fidQ;
   wire issue = regWrStb && regAddr == qa_coalesce_pkg::OFS_CMD_ISSUE;
   wire setQc = issue && regWrData[8:0] == 9'h107;
   // Only read after a write, so no reset is needed.
   always_ff @(posedge ref_clk) if (regWrStb && regAddr == 8'h00) argQ <= regWrData;
   always_ff @(posedge ref_clk) if (issue) fidQ <= regWrData[7:0];
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!arst_n);
   cpl_follows_a: assert property (issue |=> cplValid)
      else $error("No completion after an issue write.");
   cpl_needs_a: assert property (!issue |=> !cplValid)
      else $error("Completion without an issue write.");
   bad_count_a: assert property (setQc && (&argQ[31:16] || &argQ[15:0]) |=> cplInvalid)
      else $error("All-ones count field was accepted.");
   alloc_held_a: assert property (!setQc
      |=> $stable({cq_count_allocated, sq_count_allocated})) else $error("Allocation moved.");
   alloc_report_a: assert property (cplValid && !cplInvalid && fidQ == 8'h07
      |-> cplDword0 == {cq_count_allocated, sq_count_allocated}) else $error("Bad dword 0.");
   alloc_cap_a: assert property (cq_count_allocated <= 16'(MAX_CQ - 1))
      else $error("More completion queues than owned.");
   admin_direct_a: assert property (entryValid && entryVector == '0 |=> irqFire[0])
      else $error("Admin interrupt held back.");
   error_direct_a: assert property (entryValid && entryError
      |=> irqFire[$past(entryVector)]) else $error("Error completion was coalesced.");
   cover property (cplValid && cplInvalid);
   cover property (irqFire[1]);
   cover property (irqFire[3]);
endmodule
bind queue_coalesce_top qc_checker #(.NUM_VECTORS(NUM_VECTORS), .VEC_W(VEC_W), .MAX_CQ(MAX_CQ))
   qc_checker_i (.ref_clk(ref_clk), .arst_n(arst_n), .regAddr(regAddr), .regWrData(regWrData),
   .regWrStb(regWrStb), .entryValid(entryValid), .entryVector(entryVector),
   .entryError(entryError), .irqFire(irqFire), .cplValid(cplValid), .cplDword0(cplDword0),
   .cplInvalid(cplInvalid), .cq_count_allocated(cq_count_allocated),
   .sq_count_allocated(sq_count_allocated));

//--- tb/host_model.sv
// Purpose : Host software model speaking the plain register port.
// Assumes : Strobes last one cycle and change just after a rising edge.
// Notes   : A gap cycle follows every access.
`timescale 1ns/1ps
module host_model (
   input  wire logic        ref_clk,   // Clock.
   output logic      [7:0]  regAddr,   // Address.
   output logic      [31:0] regWrData, // Write data.
   output logic             regWrStb,  // Write strobe.
   output logic             regRdStb,  // Read strobe.
   input  wire logic [31:0] regRdData  // Read data.
);
   // ==========================================================================
   // Idle bus from time zero, so nothing strays in during reset.
   initial begin
      {regAddr, regWrData, regWrStb, regRdStb} = '0;
   end
   // Count fields are packed cq high, sq low, each 0 to 65,534 except on refusal tests.
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      regAddr <= a;
      regWrData <= d;
      regWrStb <= 1'b1;
      @(posedge ref_clk);
      regWrStb <= 1'b0;
   endtask
   // Read data stand only in the cycle after the strobe, so they are taken there.
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge ref_clk);
      regAddr <= a;
      regRdStb <= 1'b1;
      @(posedge ref_clk);
      regRdStb <= 1'b0;
      #1;
      d = regRdData;
   endtask
endmodule

//--- tb/queue_coalesce_top_tb.sv
// Purpose : Self-checking bench for queue_coalesce_top.
// Assumes : A time unit of 4 cycles, so a delay of 3 units fires 9 to 12 cycles after the entry is taken.
// Notes   : Register traffic goes through host_model tasks.
`timescale 1ns/1ps
module queue_coalesce_top_tb;
   logic ref_clk, arst_n, regWrStb, regRdStb, entryValid, entryError, doorbellWr, intModeChg;
   logic cplValid, cplInvalid;
   logic [7:0] regAddr, irqFire;
   logic [31:0] regWrData, regRdData, cplDword0, r;
   logic [2:0] entryVector, doorbellVec;
   int miscompares, n_tests, n;
   queue_coalesce_top #(.TICK_CYCLES(4)) queue_coalesce_top_i (.ref_clk(ref_clk),
      .arst_n(arst_n), .regAddr(regAddr), .regWrData(regWrData), .regWrStb(regWrStb),
      .regRdStb(regRdStb), .regRdData(regRdData), .entryValid(entryValid),
      .entryVector(entryVector), .entryError(entryError), .doorbellWr(doorbellWr),
      .doorbellVec(doorbellVec), .intModeChg(intModeChg), .irqFire(irqFire),
      .cplValid(cplValid), .cplDword0(cplDword0), .cplInvalid(cplInvalid),
      .cq_count_allocated(), .sq_count_allocated());
   host_model host_model_i (.ref_clk(ref_clk), .regAddr(regAddr), .regWrData(regWrData),
      .regWrStb(regWrStb), .regRdStb(regRdStb), .regRdData(regRdData));
   // ==========================================================================
   // Checking tasks.
   task automatic chk(input logic [33:0] g, input logic [33:0] e);
      n_tests++;
      if (g !== e) begin
         miscompares++;
         $display("MISMATCH %0t: got %h expected %h", $time, g, e);
      end
   endtask
   // Issue a feature command and check valid, invalid and dword 0 together.
   task automatic cmd(input logic s, input logic [7:0] f, input logic [31:0] a,
                      input logic [33:0] e);
      host_model_i.wr(qa_coalesce_pkg::OFS_CMD_ARG, a);
      host_model_i.wr(qa_coalesce_pkg::OFS_CMD_ISSUE, {23'h0, s, f});
      #1;
      chk({cplValid, cplInvalid, cplDword0}, e);
   endtask
   // Post one entry, then look at the interrupt in the one cycle it stands.
   task automatic ev(input logic [2:0] v, input logic e, input logic x);
      @(posedge ref_clk);
      entryValid <= 1'b1;
      entryVector <= v;
      entryError <= e;
      @(posedge ref_clk);
      entryValid <= 1'b0;
      entryError <= 1'b0;
      #1;
      chk({33'h0, irqFire[v]}, {33'h0, x});
   endtask
   task automatic results;
      $display("Comparisons %0d, mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   always #10 ref_clk = ~ref_clk;
   // A hang would stall far beyond the roughly 80 cycles the sequence needs.
   initial begin
      #20000;
      miscompares++;
      results;
   end
   initial begin
      {ref_clk, arst_n, entryValid, entryError, doorbellWr, intModeChg} = 6'h00;
      entryVector = 3'h0;
      doorbellVec = 3'h1;
      repeat (2) @(posedge ref_clk);
      arst_n <= 1'b1;
      repeat (3) @(posedge ref_clk);
      host_model_i.rd(8'h14, r); chk({2'b0, r}, 34'h0003F003F);
      host_model_i.rd(8'h3C, r); chk({2'b0, r}, 34'h0);
      cmd(1'b0, 8'h08, 32'h0, {2'b10, 32'h0});
      cmd(1'b1, 8'h07, 32'hFFFF0000, {2'b11, 32'h0});
      cmd(1'b1, 8'h07, 32'h00050000, {2'b10, 32'h00070003});
      cmd(1'b1, 8'h07, 32'h00640064, {2'b10, 32'h00070003});
      cmd(1'b0, 8'h07, 32'h0, {2'b10, 32'h00070003});
      cmd(1'b1, 8'h05, 32'h0, {2'b11, 32'h0});
      host_model_i.rd(qa_coalesce_pkg::OFS_STATUS, r); chk({2'b0, r}, 34'h7);
      cmd(1'b1, 8'h08, 32'h0301, {2'b10, 32'h0301});
      cmd(1'b0, 8'h08, 32'h0, {2'b10, 32'h0301});
      ev(3'h1, 1'b0, 1'b0);
      ev(3'h1, 1'b0, 1'b1);
      ev(3'h1, 1'b0, 1'b0);
      @(posedge ref_clk);
      doorbellWr <= 1'b1;
      @(posedge ref_clk);
      doorbellWr <= 1'b0;
      ev(3'h1, 1'b0, 1'b0);
      for (n = 1; n < 20 && irqFire[1] !== 1'b1; n++) @(posedge ref_clk) #1;
      chk({33'h0, n >= 8 && n <= 14}, 34'h1);
      ev(3'h2, 1'b1, 1'b1);
      ev(3'h0, 1'b0, 1'b1);
      host_model_i.wr(qa_coalesce_pkg::OFS_VEC_OFF, 32'h08);
      ev(3'h3, 1'b0, 1'b1);
      @(posedge ref_clk);
      intModeChg <= 1'b1;
      @(posedge ref_clk);
      intModeChg <= 1'b0;
      cmd(1'b0, 8'h08, 32'h0, {2'b10, 32'h0});
      ev(3'h1, 1'b0, 1'b1);
      results;
   end
endmodule
